// >>> tic_pkg.sv
// shared constants and types of the trap and interrupt control block
package tic_pkg;

   // ***************************************************
   // sizes
   // ***************************************************
   localparam int NIRQ = 15; // interrupt lines 1..15
   localparam int NCOND = 16; // synchronous trap sources
   localparam int NWIN = 8; // register windows
   localparam int WPTR_W = 3; // window pointer width
   localparam int IRQ_W = 4; // interrupt number width

   // ***************************************************
   // register offsets (byte addresses)
   // ***************************************************
   localparam logic [7:0] OFF_TBASE = 8'h00;
   localparam logic [7:0] OFF_MASK_LEVEL = 8'h04;
   localparam logic [7:0] OFF_PEND = 8'h08;
   localparam logic [7:0] OFF_FORCE = 8'h0c;
   localparam logic [7:0] OFF_CLEAR = 8'h10;
   localparam logic [7:0] OFF_WINDOW = 8'h14;
   localparam logic [7:0] OFF_FPU_KIND = 8'h18;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [19:0] TBA_RST = 20'h00000;
   localparam logic [14:0] MASK_RST = 15'h7fff; // all masked
   localparam logic [14:0] LEVEL_RST = 15'h0000;
   localparam logic [7:0] WINV_RST = 8'h00;
   localparam logic [2:0] WPTR_RST = 3'h0;
   localparam logic [31:0] RESET_VEC = 32'h00000000;

   // ***************************************************
   // trap types
   // ***************************************************
   localparam logic [7:0] TT_RESET = 8'h00; // shown only, never stored
   localparam logic [7:0] TT_IRQ_BASE = 8'h10;
   localparam logic [7:0] TT_FP_EXC = 8'h08;
   localparam logic [7:0] TT_DIV_ZERO = 8'h2a;
   localparam logic [7:0] TT_WRITE_ERR = 8'h2b;
   localparam int TICC_IDX = 15; // software trap entry
   // per source, in source order: type and priority (smaller wins)
   localparam logic [7:0] TT_TAB [NCOND] = '{8'h2b, 8'h01, 8'h03, 8'h02,
      8'h04, 8'h24, 8'h0b, 8'h05, 8'h06, 8'h20, 8'h07, 8'h08, 8'h09, 8'h0a,
      8'h2a, 8'h80};
   localparam logic [7:0] PRIO_TAB [NCOND] = '{8'h02, 8'h03, 8'h04, 8'h05,
      8'h05, 8'h06, 8'h07, 8'h08, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h0e,
      8'h0f, 8'h10};

   // ***************************************************
   // carriers
   // ***************************************************
   typedef struct packed {
      logic write_err; // store error from write buffer
      logic fetch_err; // blocking fetch error
      logic illegal; // bad opcode or illegal state
      logic priv_instr; // privileged instruction
      logic fp_instr; // floating-point instruction
      logic cp_instr; // coprocessor instruction
      logic wp_hit; // watchpoint match
      logic save; // window save
      logic restore; // window restore or trap return
      logic rf_err; // register file uncorrectable
      logic ls_misalign; // load/store misaligned
      logic xfer; // jump-and-link or trap return
      logic [1:0] xfer_tgt_lo; // low target address bits
      logic fp_exc; // fpu exception
      logic data_err; // blocking data error
      logic tag_ovf; // tagged arithmetic fault
      logic div_zero; // divide by zero
      logic ticc; // software trap, condition true
      logic [6:0] tnum; // software trap number
   } tic_cond_type;

   typedef struct packed {
      logic we; // write both saved counters
      logic [2:0] win; // target window
      logic [31:0] pc;
      logic [31:0] npc;
   } tic_save_type;

endpackage

// >>> tic_trap_sel.sv
// fixed-priority selection among synchronous trap sources
`timescale 1ns/1ps
module tic_trap_sel (
   input wire logic [tic_pkg::NCOND-1:0] cond_i,
   input wire logic [6:0] tnum_i,
   output logic valid_o,
   output logic [7:0] tt_o
);

   // ***************************************************
   // smallest priority number wins, one pass per cycle
   // ***************************************************
   always_comb begin
      logic [7:0] best;
      best = 8'hff;
      valid_o = 1'b0;
      tt_o = 8'h00;
      for (int i = 0; i < tic_pkg::NCOND; i++) begin
         if (cond_i[i] && (tic_pkg::PRIO_TAB[i] < best)) begin
            best = tic_pkg::PRIO_TAB[i];
            valid_o = 1'b1;
            // software traps land in the upper half of the table
            tt_o = (i == tic_pkg::TICC_IDX) ? {1'b1, tnum_i}
               : tic_pkg::TT_TAB[i];
         end
      end
   end

endmodule // tic_trap_sel

// >>> tic_irq_sel.sv
// two-level interrupt priority selector
`timescale 1ns/1ps
module tic_irq_sel (
   input wire logic [tic_pkg::NIRQ:1] active_i,
   input wire logic [tic_pkg::NIRQ:1] level_i,
   output logic valid_o,
   output logic [tic_pkg::IRQ_W-1:0] num_o
);

   // ***************************************************
   // highest number per level, high level first
   // ***************************************************
   always_comb begin
      logic hi_v;
      logic lo_v;
      logic [tic_pkg::IRQ_W-1:0] hi_n;
      logic [tic_pkg::IRQ_W-1:0] lo_n;
      hi_v = 1'b0;
      lo_v = 1'b0;
      hi_n = 4'h0;
      lo_n = 4'h0;
      // ascending scan: later hits overwrite, so highest number stays
      for (int i = 1; i <= tic_pkg::NIRQ; i++) begin
         if (active_i[i] && level_i[i]) begin
            hi_v = 1'b1;
            hi_n = 4'(i);
         end else if (active_i[i]) begin
            lo_v = 1'b1;
            lo_n = 4'(i);
         end
      end
      valid_o = hi_v | lo_v;
      num_o = hi_v ? hi_n : lo_n;
   end

endmodule // tic_irq_sel

// >>> tic_top.sv
// trap entry and interrupt controller of the integer unit
`timescale 1ns/1ps

// Summary of operation
// - simultaneous traps: only highest priority taken
// - trap advances window, saves both counters
// - vector is base plus type, four-instruction slots
// - reset trap first, trap type kept
// - write buffer store error gives 0x2B
// - blocking fetch error gives 0x01
// - illegal gives 0x02, user privileged 0x03
// - fpu off 0x04, coprocessor always 0x24
// - watchpoint match gives 0x0B
// - save into invalid 0x05, restore 0x06
// - register file uncorrectable error gives 0x20
// - misaligned access or transfer gives 0x07
// - fpu exception 0x08, kind recorded
// - blocking data access error gives 0x09
// - tag fault 0x0A, divide by zero 0x2A
// - software trap types 0x80 to 0xFF
// - fifteen request lines prioritised, forwarded
// - only unmasked requests become pending
// - highest high-level first, then low level
// - force acts only while unmasked, never shows pending
// - clear register ones clear pending bits
// - acknowledge clears pending, or force if forced
// - interrupt n is type 0x10+n, 15 unblocked
// - new hardware error requests interrupt 1
module tic_top (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire tic_pkg::tic_cond_type cond_i,
   input wire logic supervisor_bit_i,
   input wire logic fpu_enable_i,
   input wire logic traps_enabled_i,
   input wire logic [3:0] processor_interrupt_level_i,
   input wire logic [31:0] pc_i,
   input wire logic [31:0] npc_i,
   input wire logic [2:0] fpu_trap_kind_i,
   input wire logic [tic_pkg::NIRQ:1] irq_int_i,
   input wire logic [tic_pkg::NIRQ:1] irq_pin_i,
   input wire logic hardware_error_detected_flag_i,
   input wire logic irq_ack_i,
   input wire logic [tic_pkg::IRQ_W-1:0] irq_ack_num_i,
   output logic trap_take_o,
   output logic [7:0] trap_type_o,
   output logic [31:0] trap_vector_o,
   output tic_pkg::tic_save_type save_o,
   output logic [2:0] current_window_pointer_o,
   output logic irq_req_o,
   output logic [tic_pkg::IRQ_W-1:0] irq_num_o,
   output logic [2:0] fpu_trap_kind_o
);

   // ***************************************************
   // state
   // ***************************************************
   logic [19:0] tba_q, tba_d; // trap table base
   logic [7:0] tt_q, tt_d; // trap_type_field, not reset
   logic [14:0] mask_q, mask_d; // irq_mask_bits
   logic [14:0] level_q, level_d; // irq_level_bits
   logic [14:0] pend_q, pend_d; // irq_pending_bits
   logic [14:0] force_q, force_d; // irq_force_bits
   logic [7:0] winv_q, winv_d; // window_invalid_mask
   logic [2:0] wptr_q, wptr_d; // current_window_pointer
   logic [2:0] fkind_q, fkind_d; // fpu_trap_kind
   logic [31:0] rdata_q, rdata_d; // read data, one cycle late
   logic rst_pend_q, rst_pend_d; // reset trap owed
   logic take_q;
   logic [7:0] ttype_q;
   logic [31:0] vec_q;
   tic_pkg::tic_save_type save_q, save_d;
   logic ireq_q, ireq_d;
   logic [3:0] inum_q, inum_d;
   // pin requests: two-stage synchroniser
   logic [14:0] pin_s1_q, pin_s2_q;

   // ***************************************************
   // combinational helpers
   // ***************************************************
   logic [tic_pkg::NCOND-1:0] src; // trap sources, in table order
   logic tsel_v;
   logic [7:0] tsel_tt;
   logic isel_v;
   logic [3:0] isel_n;
   logic [14:0] req_v; // all raw requests
   logic [14:0] ack_v; // acknowledge as one-hot
   logic [14:0] set_v; // unmasked requests, the only way into pending
   logic [2:0] wptr_dn, wptr_up;
   logic wovf, wunf, irq_ok, take_d;
   logic [7:0] ttn;
   logic [31:0] vec_d;

   // next and previous window, wrap by width
   assign wptr_dn = wptr_q - 3'h1;
   assign wptr_up = wptr_q + 3'h1;
   assign wovf = cond_i.save && winv_q[wptr_dn];
   assign wunf = cond_i.restore && winv_q[wptr_up];

   // ***************************************************
   // trap source vector
   // ***************************************************
   always_comb begin
      src = '0;
      src[0] = cond_i.write_err;
      src[1] = cond_i.fetch_err;
      src[2] = cond_i.priv_instr && !supervisor_bit_i;
      src[3] = cond_i.illegal;
      src[4] = cond_i.fp_instr && !fpu_enable_i;
      src[5] = cond_i.cp_instr;
      src[6] = cond_i.wp_hit;
      src[7] = wovf;
      src[8] = wunf;
      src[9] = cond_i.rf_err;
      // only low two bits matter for word alignment
      src[10] = cond_i.ls_misalign || (cond_i.xfer && (|cond_i.xfer_tgt_lo));
      src[11] = cond_i.fp_exc;
      src[12] = cond_i.data_err;
      src[13] = cond_i.tag_ovf;
      src[14] = cond_i.div_zero;
      src[15] = cond_i.ticc;
   end

   tic_trap_sel u_trap_sel (
      .cond_i(src),
      .tnum_i(cond_i.tnum),
      .valid_o(tsel_v),
      .tt_o(tsel_tt)
   );

   // forced bits count only while unmasked; they stay out of pending
   tic_irq_sel u_irq_sel (
      .active_i((pend_q | force_q) & ~mask_q),
      .level_i(level_q),
      .valid_o(isel_v),
      .num_o(isel_n)
   );

   // ***************************************************
   // request and acknowledge vectors
   // ***************************************************
   always_comb begin
      // interrupt 1 doubles as the hardware error report
      req_v = pin_s2_q | irq_int_i | {14'h0000, hardware_error_detected_flag_i};
      set_v = req_v & ~mask_q;
      ack_v = '0;
      if (irq_ack_i && (irq_ack_num_i != 4'h0)) begin
         ack_v[irq_ack_num_i - 4'h1] = 1'b1;
      end
   end

   // ***************************************************
   // trap decision
   // ***************************************************
   always_comb begin
      // level 15 bypasses the processor level compare
      irq_ok = isel_v && traps_enabled_i
         && ((isel_n == 4'hf) || (isel_n > processor_interrupt_level_i));
      // reset beats all; sync traps beat interrupts
      take_d = rst_pend_q || tsel_v || irq_ok;
      if (rst_pend_q) begin
         ttn = tic_pkg::TT_RESET;
      end else if (tsel_v) begin
         ttn = tsel_tt;
      end else begin
         ttn = tic_pkg::TT_IRQ_BASE + {4'h0, isel_n};
      end
      // sixteen bytes per slot hold four instructions
      vec_d = rst_pend_q ? tic_pkg::RESET_VEC : {tba_q, ttn, 4'h0};
   end

   // ***************************************************
   // next state of all registers but take, type, vector and the pin stages
   // ***************************************************
   always_comb begin
      tba_d = tba_q;
      tt_d = tt_q;
      mask_d = mask_q;
      level_d = level_q;
      winv_d = winv_q;
      wptr_d = wptr_q;
      fkind_d = fkind_q;
      force_d = force_q;
      rdata_d = 32'h00000000;
      rst_pend_d = 1'b0;
      // software writes
      if (wr_i) begin
         case (addr_i)
            tic_pkg::OFF_TBASE: tba_d = wdata_i[31:12];
            tic_pkg::OFF_MASK_LEVEL: begin
               mask_d = wdata_i[15:1];
               level_d = wdata_i[31:17];
            end
            tic_pkg::OFF_FORCE: force_d = wdata_i[15:1];
            tic_pkg::OFF_WINDOW: begin
               winv_d = wdata_i[15:8];
               wptr_d = wdata_i[2:0];
            end
            default: ; // others read-only or strobe-only
         endcase
      end
      // acknowledging a forced interrupt drops the force bit
      force_d = force_d & ~(ack_v & force_q);
      // pending: set beats clear, masked never sets
      pend_d = (pend_q
         & ~((wr_i && (addr_i == tic_pkg::OFF_CLEAR)) ? wdata_i[15:1] : 15'h0000)
         & ~(ack_v & ~force_q))
         | set_v;
      // window moves: trap entry wins over save/restore
      if (take_d) begin
         wptr_d = wptr_dn;
      end else if (cond_i.save) begin
         wptr_d = wptr_dn;
      end else if (cond_i.restore) begin
         wptr_d = wptr_up;
      end
      // reset trap leaves the stored type for post-mortem;
      // the type register is not reset, so no trap may land in it while reset is held
      if (take_d && !rst_pend_q && nrst_i) begin
         tt_d = ttn;
      end
      if (take_d && !rst_pend_q && tsel_v && (tsel_tt == tic_pkg::TT_FP_EXC)) begin
         fkind_d = fpu_trap_kind_i;
      end
      // read mux, unmapped reads zero
      if (rd_i) begin
         case (addr_i)
            tic_pkg::OFF_TBASE: rdata_d = {tba_q, tt_q, 4'h0};
            tic_pkg::OFF_MASK_LEVEL: rdata_d = {level_q, 1'b0, mask_q, 1'b0};
            tic_pkg::OFF_PEND: rdata_d = {16'h0000, pend_q, 1'b0};
            tic_pkg::OFF_FORCE: rdata_d = {16'h0000, force_q, 1'b0};
            tic_pkg::OFF_WINDOW: rdata_d = {16'h0000, winv_q, 5'h00, wptr_q};
            tic_pkg::OFF_FPU_KIND: rdata_d = {29'h00000000, fkind_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
      // counters saved into the window being entered
      save_d.we = take_d;
      save_d.win = wptr_dn;
      save_d.pc = pc_i;
      save_d.npc = npc_i;
      // forward selected interrupt to the integer unit
      ireq_d = isel_v;
      inum_d = isel_n;
   end

   // ***************************************************
   // registers; trap type survives reset on purpose
   // ***************************************************
   always_ff @(posedge clk_sys_i) begin
      tt_q <= tt_d;
      pin_s1_q <= irq_pin_i;
      pin_s2_q <= pin_s1_q;
      if (!nrst_i) begin
         tba_q <= tic_pkg::TBA_RST;
         mask_q <= tic_pkg::MASK_RST;
         level_q <= tic_pkg::LEVEL_RST;
         pend_q <= 15'h0000;
         force_q <= 15'h0000;
         winv_q <= tic_pkg::WINV_RST;
         wptr_q <= tic_pkg::WPTR_RST;
         fkind_q <= 3'h0;
         rdata_q <= 32'h00000000;
         rst_pend_q <= 1'b1; // reset trap owed at release
         take_q <= 1'b0;
         ttype_q <= 8'h00;
         vec_q <= 32'h00000000;
         save_q <= '0;
         ireq_q <= 1'b0;
         inum_q <= 4'h0;
      end else begin
         tba_q <= tba_d;
         mask_q <= mask_d;
         level_q <= level_d;
         pend_q <= pend_d;
         force_q <= force_d;
         winv_q <= winv_d;
         wptr_q <= wptr_d;
         fkind_q <= fkind_d;
         rdata_q <= rdata_d;
         rst_pend_q <= rst_pend_d;
         take_q <= take_d;
         ttype_q <= ttn;
         vec_q <= vec_d;
         save_q <= save_d;
         ireq_q <= ireq_d;
         inum_q <= inum_d;
      end
   end

   assign rdata_o = rdata_q;
   assign trap_take_o = take_q;
   assign trap_type_o = ttype_q;
   assign trap_vector_o = vec_q;
   assign save_o = save_q;
   assign current_window_pointer_o = wptr_q;
   assign irq_req_o = ireq_q;
   assign irq_num_o = inum_q;
   assign fpu_trap_kind_o = fkind_q;

   // ***************************************************
   // assertions
   // ***************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   sequence s_release;
      $rose(nrst_i);
   endsequence
   sequence s_reset_entry;
      trap_take_o && (trap_vector_o == tic_pkg::RESET_VEC);
   endsequence

   AST_RESET_FIRST: assert property (s_release |=> s_reset_entry)
      else $error("reset trap not taken after release");
   AST_RESET_KEEPS_TT: assert property (rst_pend_q |=> $stable(tt_q))
      else $error("reset trap changed trap type");
   AST_WRITE_ERR_WINS: assert property (
      (!rst_pend_q && cond_i.write_err && cond_i.div_zero)
      |=> trap_take_o && (trap_type_o == tic_pkg::TT_WRITE_ERR))
      else $error("lower priority trap won");
   AST_DIV_TYPE: assert property (
      (!rst_pend_q && (src == 16'h4000)) |=> (trap_type_o == tic_pkg::TT_DIV_ZERO))
      else $error("divide trap type wrong");
   AST_VECTOR: assert property (
      (trap_take_o && (trap_vector_o != tic_pkg::RESET_VEC))
      |-> (trap_vector_o[11:4] == trap_type_o) && (trap_vector_o[3:0] == 4'h0))
      else $error("trap vector not base plus type");
   AST_WINDOW_SAVE: assert property (
      trap_take_o |-> save_o.we && (save_o.win == wptr_q)
      && (wptr_q == $past(wptr_q) - 3'h1))
      else $error("window not advanced on trap");
   AST_PEND_ONLY_UNMASKED: assert property (
      ((pend_q & ~$past(pend_q) & ~$past(set_v)) == 15'h0000))
      else $error("pending set without unmasked request");
   AST_CLEAR: assert property (
      (wr_i && (addr_i == tic_pkg::OFF_CLEAR) && ((req_v & wdata_i[15:1]) == 15'h0000))
      |=> ((pend_q & $past(wdata_i[15:1])) == 15'h0000))
      else $error("clear write left pending bit");
   AST_ACK_FORCED: assert property (
      (((ack_v & force_q) != 15'h0000) && !(wr_i && (addr_i == tic_pkg::OFF_FORCE)))
      |=> ((force_q & $past(ack_v)) == 15'h0000))
      else $error("acknowledge left force bit");
   AST_IRQ_TYPE: assert property (
      (!rst_pend_q && !tsel_v && irq_ok)
      |=> trap_take_o && (trap_type_o == 8'(tic_pkg::TT_IRQ_BASE + $past(isel_n))))
      else $error("interrupt trap type wrong");

endmodule // tic_top

// >>> tic_iu_model.sv
// integer unit stand-in that acknowledges forwarded interrupts
`timescale 1ns/1ps
module tic_iu_model #(
   parameter int DELAY = 2
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic irq_req_i,
   input wire logic [3:0] irq_num_i,
   output logic ack_o,
   output logic [3:0] ack_num_o
);
   // ***************************************************
   // acknowledge
   // ***************************************************
   int wait_q; // cycles left before the acknowledge
   // one ack pulse per request, after a delay; the number wanders outside acks
   always @(posedge clk_i) begin
      if (!nrst_i || !en_i || ack_o) begin
         ack_o <= 1'b0;
         wait_q <= DELAY;
         ack_num_o <= 4'ha;
      end else if (irq_req_i && wait_q == 0) begin
         ack_o <= 1'b1;
         ack_num_o <= irq_num_i;
      end else begin
         ack_o <= 1'b0;
         ack_num_o <= ~ack_num_o;
         if (irq_req_i) begin
            wait_q <= wait_q - 1;
         end
      end
   end
endmodule // tic_iu_model

// >>> trap_and_interrupt_control_tb.sv
// self-checking bench for trap entry and the interrupt controller
`timescale 1ns/1ps
module trap_and_interrupt_control_tb;
   typedef struct packed {
      logic [25:0] c;
      logic sup;
      logic fpe;
      logic [7:0] tt;
   } tic_row_type; // conditions, modes, expected type (0 = no trap)
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   tic_pkg::tic_cond_type cond_i = '0;
   logic supervisor_bit_i = 1'b1;
   logic fpu_enable_i = 1'b1;
   logic traps_enabled_i = 1'b0;
   logic [3:0] processor_interrupt_level_i = 4'hf;
   logic [31:0] pc_i = 32'h0;
   logic [31:0] npc_i = 32'h0;
   logic [2:0] fpu_trap_kind_i = 3'h5;
   logic [15:1] irq_int_i = '0;
   logic [15:1] irq_pin_i = '0;
   logic hed_i = 1'b0;
   logic ack_i;
   logic [3:0] ack_num_i;
   logic iu_en = 1'b0; // partner acknowledges only when set
   logic trap_take_o;
   logic [7:0] trap_type_o;
   logic [31:0] trap_vector_o;
   tic_pkg::tic_save_type save_o;
   logic [2:0] wptr_o;
   logic irq_req_o;
   logic [3:0] irq_num_o;
   logic [2:0] fpu_trap_kind_o;
   logic [2:0] win; // expected window pointer
   int fail_count = 0;
   int total_checks = 0;
   int i;
   tic_row_type rows [27] = '{
      '{26'h2000000, 1'b1, 1'b1, 8'h2b}, '{26'h1000000, 1'b1, 1'b1, 8'h01},
      '{26'h0800000, 1'b1, 1'b1, 8'h02}, '{26'h0400000, 1'b0, 1'b1, 8'h03},
      '{26'h0200000, 1'b1, 1'b0, 8'h04}, '{26'h0100000, 1'b1, 1'b1, 8'h24},
      '{26'h0080000, 1'b1, 1'b1, 8'h0b}, '{26'h0040000, 1'b1, 1'b1, 8'h05},
      '{26'h0020000, 1'b1, 1'b1, 8'h06}, '{26'h0010000, 1'b1, 1'b1, 8'h20},
      '{26'h0008000, 1'b1, 1'b1, 8'h07}, '{26'h0006000, 1'b1, 1'b1, 8'h07},
      '{26'h0000800, 1'b1, 1'b1, 8'h08}, '{26'h0000400, 1'b1, 1'b1, 8'h09},
      '{26'h0000200, 1'b1, 1'b1, 8'h0a}, '{26'h0000100, 1'b1, 1'b1, 8'h2a},
      '{26'h00000ff, 1'b1, 1'b1, 8'hff}, '{26'h0000080, 1'b1, 1'b1, 8'h80},
      '{26'h3ffffff, 1'b0, 1'b0, 8'h2b}, '{26'h1ffffff, 1'b0, 1'b0, 8'h01},
      '{26'h0c00000, 1'b0, 1'b1, 8'h03}, '{26'h0a00000, 1'b1, 1'b0, 8'h02},
      '{26'h0000380, 1'b1, 1'b1, 8'h0a}, '{26'h0060000, 1'b1, 1'b1, 8'h05},
      '{26'h0400000, 1'b1, 1'b1, 8'h00}, '{26'h0200000, 1'b1, 1'b1, 8'h00},
      '{26'h0004000, 1'b1, 1'b1, 8'h00}};

   tic_top DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cond_i(cond_i),
      .supervisor_bit_i(supervisor_bit_i), .fpu_enable_i(fpu_enable_i),
      .traps_enabled_i(traps_enabled_i),
      .processor_interrupt_level_i(processor_interrupt_level_i), .pc_i(pc_i), .npc_i(npc_i),
      .fpu_trap_kind_i(fpu_trap_kind_i), .irq_int_i(irq_int_i), .irq_pin_i(irq_pin_i),
      .hardware_error_detected_flag_i(hed_i), .irq_ack_i(ack_i), .irq_ack_num_i(ack_num_i),
      .trap_take_o(trap_take_o), .trap_type_o(trap_type_o), .trap_vector_o(trap_vector_o),
      .save_o(save_o), .current_window_pointer_o(wptr_o), .irq_req_o(irq_req_o),
      .irq_num_o(irq_num_o), .fpu_trap_kind_o(fpu_trap_kind_o));
   tic_iu_model #(.DELAY(2)) iu (.clk_i(clk_sys_i), .nrst_i(nrst_i), .en_i(iu_en),
      .irq_req_i(irq_req_o), .irq_num_i(irq_num_o), .ack_o(ack_i), .ack_num_o(ack_num_i));

   // ***************************************************
   // helpers
   // ***************************************************
   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, e);
   endtask
   task automatic do_reset();
      @(posedge clk_sys_i);
      nrst_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      #1;
      chk({trap_take_o, trap_type_o, wptr_o}, {1'b1, 8'h00, 3'h7});
      chk(trap_vector_o, 32'h0);
      win = 3'h7;
   endtask
   // one instruction's conditions, trap expected on the next edge
   task automatic trap(input tic_row_type r);
      @(posedge clk_sys_i);
      cond_i <= r.c;
      supervisor_bit_i <= r.sup;
      fpu_enable_i <= r.fpe;
      pc_i <= {r.tt, 24'h000104};
      npc_i <= {24'h000108, r.tt};
      @(posedge clk_sys_i);
      cond_i <= '0;
      #1;
      chk(trap_take_o, r.tt != 8'h00);
      if (r.tt != 8'h00) begin
         win = win - 3'h1;
         chk(trap_type_o, r.tt);
         chk(trap_vector_o, {20'habcde, r.tt, 4'h0});
         chk({save_o.we, save_o.win, wptr_o}, {1'b1, win, win});
         chk(save_o.pc, {r.tt, 24'h000104});
         chk(save_o.npc, {24'h000108, r.tt});
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // hang guard, well beyond the expected run
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      fail_count++;
      stop_test();
   end

   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      do_reset();
      wr(8'h00, 32'habcde000);
      wr(8'h14, 32'h0000ff07); // every window invalid
      for (i = 0; i < 27; i++) begin
         trap(rows[i]);
      end
      chk(fpu_trap_kind_o, 3'h5);
      rd(8'h40, 32'h0);
      do_reset();
      rd(8'h00, {20'h0, 8'h05, 4'h0});
      wr(8'h04, 32'h00200004); // irq5 high level, irq2 masked
      @(posedge clk_sys_i);
      irq_int_i <= 15'h0116;
      @(posedge clk_sys_i);
      irq_int_i <= '0;
      rd(8'h08, 32'h228);
      chk({irq_req_o, irq_num_o}, {1'b1, 4'h5});
      wr(8'h10, 32'h20);
      rd(8'h08, 32'h208);
      chk(irq_num_o, 4'h9);
      wr(8'h0c, 32'h4);
      rd(8'h08, 32'h208);
      chk(irq_num_o, 4'h9);
      wr(8'h0c, 32'h1000);
      rd(8'h08, 32'h208);
      chk(irq_num_o, 4'hc);
      @(posedge clk_sys_i);
      hed_i <= 1'b1;
      irq_pin_i <= 15'h0008;
      @(posedge clk_sys_i);
      hed_i <= 1'b0;
      @(posedge clk_sys_i);
      irq_pin_i <= '0;
      repeat (3) @(posedge clk_sys_i);
      rd(8'h08, 32'h21a);
      traps_enabled_i <= 1'b1;
      wr(8'h0c, 32'h9000);
      for (i = 0; i < 8; i++) begin
         @(posedge clk_sys_i);
         #1;
         if (trap_take_o === 1'b1) break;
      end
      chk({trap_take_o, trap_type_o}, {1'b1, 8'h1f});
      iu_en <= 1'b1;
      repeat (40) @(posedge clk_sys_i);
      rd(8'h0c, 32'h0);
      rd(8'h08, 32'h0);
      stop_test();
   end
endmodule // trap_and_interrupt_control_tb
